// file: pkg/arbc_defs.vh
// Constants of the audio record and bypass control block.
// Assumes one 10 MHz clock and an APB master with 32-bit data.
//
// Summary of operation
// [R1] Record modulator runs at 128 times the selected sample rate.
// [R2] Decimation high-pass cutoff selectable: 0.000019, 0.000078 or 0.1 Fs.
// [R3] Record modulator and decimator clock scales with the sample rate.
// [R4] Record latency is 28.7 sample periods at any sample rate.
// [R5] Record volume +20 dB to -40 dB in 0.5 dB steps, plus mute.
// [R6] Two-bit field picks the left record channel source.
// [R7] Two-bit field picks microphone preamp gain 0, 6 or 12 dB.
// [R8] Bypass volume +12.0 dB to -35.5 dB in 0.5 dB steps.
// [R9] Applied bypass volume steps once per 20 us toward target.
// [R10] Bypass power-up starts at mute, then steps up.
// [R11] Bypass power-down steps to mute first, then removes power.
// [R12] Host powers converters down when only bypass is used.
// [R13] One bit picks mono source: headphone mix or left record input.
// [R14] One bit disables the microphone bias output.
// [R15] Each section has its own power-down bit in one register.
// [R16] Bits 15,14 set: all down; bit 15 only: all but reference.
// [R17] Host should power down every unused section.
// [R18] High-pass code: 00 off, 01 0.1, 10 0.000078, 11 0.000019 Fs.
// [R19] Source code: 00 mic, 01 left line, 10 right line, 11 mean.
// [R20] Preamp code: 00,01 0 dB, 10 6 dB, 11 12 dB.
// [R21] New bypass target mid-ramp: continue from current level.
`ifndef ARBC_DEFS_VH
`define ARBC_DEFS_VH

// Register byte offsets
`define ARBC_OFS_CTRL   8'h00
`define ARBC_OFS_ADCVOL 8'h04
`define ARBC_OFS_BYPVOL 8'h08
`define ARBC_OFS_MISC   8'h0c
`define ARBC_OFS_PWR    8'h10
`define ARBC_OFS_STAT   8'h14

// Reset values
`define ARBC_RST_CTRL   16'hc001
`define ARBC_RST_ADCVOL 16'h2828
`define ARBC_RST_BYPVOL 16'h4848
`define ARBC_RST_MISC   16'h0000
`define ARBC_RST_PWR    16'hff70

// Control register fields and misc mono-source bit
`define ARBC_HPF_LSB   14
`define ARBC_LSRC_LSB  12
`define ARBC_RSRC_LSB  10
`define ARBC_MIC_PREAMP_GAIN_SELECT_LSB  8
`define ARBC_MCLK_LSB  6
`define ARBC_FS_LSB    2
`define ARBC_FMT_LSB   0
`define ARBC_MONO_SOURCE_SELECT_BIT  2

// Power register bits
`define ARBC_PD_ALL    15
`define ARBC_PD_VCM    14
`define ARBC_PD_BYP    13
`define ARBC_PD_HP     12
`define ARBC_PD_MONO   11
`define ARBC_PD_DAC    10
`define ARBC_PD_ADCL   9
`define ARBC_PD_ADCR   8
`define ARBC_PD_MICB   6
`define ARBC_PD_OSC    5
`define ARBC_PD_CLKBUF 4

// Volume codes and highest valid sample-rate code
`define ARBC_ADC_MAXCODE 7'd120
`define ARBC_BYP_MAXLVL  7'd96
`define ARBC_BYP_MUTE    7'd0
`define ARBC_FS_MAXCODE  4'h8

// Rates and timing
`define ARBC_OSR          128
`define ARBC_LAT_TENTHS   287
`define ARBC_CLK_NS       100
`define ARBC_STEP_NS      20000
`define ARBC_STEP_CYC     ((`ARBC_STEP_NS + `ARBC_CLK_NS - 1) / `ARBC_CLK_NS)
`define ARBC_LAT_TICKS    ((`ARBC_LAT_TENTHS * `ARBC_OSR + 9) / 10)

`endif

// file: rtl/arbc_rate_cfg.v
// Record path rate decoding: modulator divide, high-pass setup, latency.
// Assumes control fields come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "arbc_defs.vh"

module arbc_rate_cfg (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire [1:0]  hpfSel,
  input  wire [1:0]  mclkRatio,
  input  wire [3:0]  fsCode,
  output reg         hpfEnable_ff,
  output reg  [1:0]  hpfCutoff_ff,
  output reg  [2:0]  modClkDiv_ff,
  output reg  [7:0]  decimRatio_ff,
  output reg  [12:0] latencyTicks_ff,
  output reg         fsInvalid_ff
);

  // Full-width copies so the outputs take a deliberate slice
  localparam [31:0] OSR_W = `ARBC_OSR;
  localparam [31:0] LAT_W = `ARBC_LAT_TICKS;

  // =========================================================
  // Decode
  // =========================================================
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hpfEnable_ff    <= 1'b1;
      hpfCutoff_ff    <= 2'h3;
      modClkDiv_ff    <= 3'h2;
      decimRatio_ff   <= 8'h80;
      latencyTicks_ff <= 13'h0e5a;
      fsInvalid_ff    <= 1'b0;
    end else begin
      // [R18] Zero code bypasses the high-pass
      hpfEnable_ff  <= (hpfSel != 2'h0);
      // [R2] Cutoff selection forwarded
      hpfCutoff_ff  <= hpfSel;
      // [R1] [R3] Modulator clock is master clock over ratio/128
      case (mclkRatio)
        2'h1:    modClkDiv_ff <= 3'h3;
        2'h2:    modClkDiv_ff <= 3'h4;
        default: modClkDiv_ff <= 3'h2;
      endcase
      decimRatio_ff   <= OSR_W[7:0];
      // [R4] Latency in modulator ticks
      latencyTicks_ff <= LAT_W[12:0];
      fsInvalid_ff    <= (fsCode > `ARBC_FS_MAXCODE);
    end
  end

endmodule
`default_nettype wire

// file: rtl/arbc_top.v
// Audio record and bypass control: APB registers, bypass soft-step.
// Assumes APB clocked by ref_clk at 10 MHz; analog blocks use outputs.
`timescale 1ns/100ps
`default_nettype none
`include "arbc_defs.vh"

module arbc_top (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [1:0]  recordHighpassSelect,
  output wire        hpfEnable,
  output wire [1:0]  hpfCutoff,
  output wire [2:0]  modClkDiv,
  output wire [7:0]  decimRatio,
  output wire [12:0] latencyTicks,
  output wire [1:0]  leftRecordSourceSelect,
  output wire [1:0]  rightRecordSourceSelect,
  output wire [1:0]  micPreampGainSelect,
  output wire [1:0]  micPreampGainDb6,
  output wire [6:0]  adcLeftGain,
  output wire        adcLeftMute,
  output wire [6:0]  adcRightGain,
  output wire        adcRightMute,
  output wire [6:0]  bypassLeftLevel,
  output wire [6:0]  bypassRightLevel,
  output wire        bypassPowerDown,
  output wire        monoSourceSelect,
  output wire        micBiasPowerDown,
  output wire        headphonePowerDown,
  output wire        monoPowerDown,
  output wire        dacPowerDown,
  output wire        adcLeftPowerDown,
  output wire        adcRightPowerDown,
  output wire        oscPowerDown,
  output wire        clkBufPowerDown,
  output wire        commonModeRefPowerDown
);

  localparam ST_OFF  = 2'h0;
  localparam ST_ON   = 2'h1;
  localparam ST_DOWN = 2'h2;

  // =========================================================
  // Functions
  // =========================================================
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `ARBC_OFS_CTRL) || (a == `ARBC_OFS_ADCVOL) ||
               (a == `ARBC_OFS_BYPVOL) || (a == `ARBC_OFS_MISC) ||
               (a == `ARBC_OFS_PWR) || (a == `ARBC_OFS_STAT);
    end
  endfunction

  function [6:0] clampByp;
    input [6:0] lvl;
    begin
      clampByp = (lvl > `ARBC_BYP_MAXLVL) ? `ARBC_BYP_MAXLVL : lvl;
    end
  endfunction

  function adcMuted;
    input [7:0] fld;
    begin
      adcMuted = fld[7] || (fld[6:0] > `ARBC_ADC_MAXCODE);
    end
  endfunction

  // =========================================================
  // Registers
  // =========================================================
  reg  [15:0] ctrl_ff;
  reg  [15:0] adcVol_ff;
  reg  [15:0] bypVol_ff;
  reg  [15:0] misc_ff;
  reg  [15:0] pwr_ff;
  reg  [1:0]  bypState_ff;
  reg  [1:0]  nxt_bypState;
  reg  [7:0]  stepCnt_ff;
  reg  [7:0]  nxt_stepCnt;
  reg  [31:0] nxt_prdata;
  wire        setupPhase;
  wire        accessPhase;
  wire        wrEn;
  wire        stepTick;
  wire        bypassReq;
  wire        rampBusy;
  wire        fsInvalid;
  wire [13:0] bypLevels;
  wire [13:0] bypTargets;
  wire [31:0] statusWord;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrEn        = accessPhase && pwrite && mapped(paddr);
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && !mapped(paddr);

  // =========================================================
  // APB write
  // =========================================================
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff   <= `ARBC_RST_CTRL;
      adcVol_ff <= `ARBC_RST_ADCVOL;
      bypVol_ff <= `ARBC_RST_BYPVOL;
      misc_ff   <= `ARBC_RST_MISC;
      pwr_ff    <= `ARBC_RST_PWR;
    end else if (wrEn) begin
      case (paddr)
        `ARBC_OFS_CTRL:   ctrl_ff   <= pwdata[15:0];
        // [R5] Record volume codes and mutes
        `ARBC_OFS_ADCVOL: adcVol_ff <= pwdata[15:0];
        // [R8] [R21] New bypass target any time
        `ARBC_OFS_BYPVOL: bypVol_ff <= {1'b0, pwdata[14:8], 1'b0, pwdata[6:0]};
        `ARBC_OFS_MISC:   misc_ff   <= {13'h0000, pwdata[2], 2'h0};
        // [R15] Per-section power-down bits
        `ARBC_OFS_PWR:    pwr_ff    <= {pwdata[15:8], 1'b0, pwdata[6:4], 4'h0};
        default: begin
        end
      endcase
    end
  end

  // =========================================================
  // APB read
  // =========================================================
  assign statusWord = {13'h0000, fsInvalid, bypState_ff, rampBusy,
                       bypLevels[13:7], 1'b0, bypLevels[6:0]};

  always @* begin
    case (paddr)
      `ARBC_OFS_CTRL:   nxt_prdata = {16'h0000, ctrl_ff};
      `ARBC_OFS_ADCVOL: nxt_prdata = {16'h0000, adcVol_ff};
      `ARBC_OFS_BYPVOL: nxt_prdata = {16'h0000, bypVol_ff};
      `ARBC_OFS_MISC:   nxt_prdata = {16'h0000, misc_ff};
      `ARBC_OFS_PWR:    nxt_prdata = {16'h0000, pwr_ff};
      `ARBC_OFS_STAT:   nxt_prdata = statusWord;
      default:          nxt_prdata = 32'h00000000;
    endcase
  end

  // Read data captured in setup so it is stable through access
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h00000000 : nxt_prdata;
    end
  end

  // =========================================================
  // Bypass power sequencing
  // =========================================================
  assign bypassReq = !pwr_ff[`ARBC_PD_BYP] && !pwr_ff[`ARBC_PD_ALL];

  always @* begin
    case (bypState_ff)
      // [R10] Power-up enters ramp with levels at mute
      ST_OFF:  nxt_bypState = bypassReq ? ST_ON : ST_OFF;
      ST_ON:   nxt_bypState = bypassReq ? ST_ON : ST_DOWN;
      ST_DOWN: begin
        if (bypassReq) begin
          nxt_bypState = ST_ON;
        // [R11] Power removed only once both channels reach mute
        end else if (bypLevels == 14'h0000) begin
          nxt_bypState = ST_OFF;
        end else begin
          nxt_bypState = ST_DOWN;
        end
      end
      default: nxt_bypState = ST_OFF;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bypState_ff <= ST_OFF;
    end else begin
      bypState_ff <= nxt_bypState;
    end
  end

  // [R11] Circuit stays powered until ramp-down ends
  assign bypassPowerDown = (bypState_ff == ST_OFF);

  // =========================================================
  // Soft-step timer
  // =========================================================
  always @* begin
    if (bypState_ff == ST_OFF || stepTick) begin
      nxt_stepCnt = 8'h00;
    end else begin
      nxt_stepCnt = stepCnt_ff + 8'h01;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stepCnt_ff <= 8'h00;
    end else begin
      stepCnt_ff <= nxt_stepCnt;
    end
  end

  // [R9] One step every 20 us
  assign stepTick = (stepCnt_ff == (`ARBC_STEP_CYC - 1));

  // =========================================================
  // Per-channel bypass level ramp
  // =========================================================
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : lane
      reg  [6:0] lvl_ff;
      reg  [6:0] nxt_lvl;
      wire [6:0] tgt;

      // [R11] Ramp-down target is mute
      assign tgt = (bypState_ff == ST_ON) ? clampByp(bypVol_ff[g*8 +: 7])
                                           : `ARBC_BYP_MUTE;

      always @* begin
        if (bypState_ff == ST_OFF) begin
          nxt_lvl = `ARBC_BYP_MUTE;
        // [R9] [R21] Step from current level toward newest target
        end else if (stepTick && lvl_ff < tgt) begin
          nxt_lvl = lvl_ff + 7'd1;
        end else if (stepTick && lvl_ff > tgt) begin
          nxt_lvl = lvl_ff - 7'd1;
        end else begin
          nxt_lvl = lvl_ff;
        end
      end

      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          lvl_ff <= `ARBC_BYP_MUTE;
        end else begin
          lvl_ff <= nxt_lvl;
        end
      end

      assign bypLevels[g*7 +: 7]  = lvl_ff;
      assign bypTargets[g*7 +: 7] = tgt;
    end
  endgenerate

  assign rampBusy         = (bypLevels != bypTargets);
  assign bypassRightLevel = bypLevels[6:0];
  assign bypassLeftLevel  = bypLevels[13:7];

  // =========================================================
  // Record path settings
  // =========================================================
  // [R18] [R2] High-pass code forwarded as written
  assign recordHighpassSelect    = ctrl_ff[`ARBC_HPF_LSB +: 2];
  // [R6] [R19] Source codes drive the input multiplexers
  assign leftRecordSourceSelect  = ctrl_ff[`ARBC_LSRC_LSB +: 2];
  assign rightRecordSourceSelect = ctrl_ff[`ARBC_RSRC_LSB +: 2];
  // [R7] Preamp gain field
  assign micPreampGainSelect     = ctrl_ff[`ARBC_MIC_PREAMP_GAIN_SELECT_LSB +: 2];
  // [R20] Gain in 6 dB units: codes 00 and 01 give zero
  assign micPreampGainDb6 = micPreampGainSelect[1] ?
                            {1'b0, 1'b1} + {1'b0, micPreampGainSelect[0]} :
                            2'h0;

  // [R5] Codes above the range read as mute
  assign adcLeftGain  = adcVol_ff[14:8];
  assign adcLeftMute  = adcMuted(adcVol_ff[15:8]) || adcLeftPowerDown;
  assign adcRightGain = adcVol_ff[6:0];
  assign adcRightMute = adcMuted(adcVol_ff[7:0]) || adcRightPowerDown;

  // [R1] [R3] [R4] Rate-tracking record clocking
  arbc_rate_cfg u_rate (
    .ref_clk         (ref_clk),
    .arst_n          (arst_n),
    .hpfSel          (ctrl_ff[`ARBC_HPF_LSB +: 2]),
    .mclkRatio       (ctrl_ff[`ARBC_MCLK_LSB +: 2]),
    .fsCode          (ctrl_ff[`ARBC_FS_LSB +: 4]),
    .hpfEnable_ff    (hpfEnable),
    .hpfCutoff_ff    (hpfCutoff),
    .modClkDiv_ff    (modClkDiv),
    .decimRatio_ff   (decimRatio),
    .latencyTicks_ff (latencyTicks),
    .fsInvalid_ff    (fsInvalid)
  );

  // =========================================================
  // Mono, bias and power-down outputs
  // =========================================================
  // [R13] Mono source bit
  assign monoSourceSelect = misc_ff[`ARBC_MONO_SOURCE_SELECT_BIT];

  // [R14] [R16] Bias disable, forced by global power-down
  assign micBiasPowerDown   = pwr_ff[`ARBC_PD_MICB] | pwr_ff[`ARBC_PD_ALL];
  // [R15] [R16] Section power-downs with global override
  assign headphonePowerDown = pwr_ff[`ARBC_PD_HP] | pwr_ff[`ARBC_PD_ALL];
  assign monoPowerDown      = pwr_ff[`ARBC_PD_MONO] | pwr_ff[`ARBC_PD_ALL];
  assign dacPowerDown       = pwr_ff[`ARBC_PD_DAC] | pwr_ff[`ARBC_PD_ALL];
  assign adcLeftPowerDown   = pwr_ff[`ARBC_PD_ADCL] | pwr_ff[`ARBC_PD_ALL];
  assign adcRightPowerDown  = pwr_ff[`ARBC_PD_ADCR] | pwr_ff[`ARBC_PD_ALL];
  assign oscPowerDown       = pwr_ff[`ARBC_PD_OSC] | pwr_ff[`ARBC_PD_ALL];
  assign clkBufPowerDown    = pwr_ff[`ARBC_PD_CLKBUF] | pwr_ff[`ARBC_PD_ALL];
  // [R16] Reference kept up unless both top bits set
  assign commonModeRefPowerDown = pwr_ff[`ARBC_PD_ALL] & pwr_ff[`ARBC_PD_VCM];

endmodule
`default_nettype wire

// file: sim/arbc_monitor.sv
// Checker of the record and bypass control block, bound to its top.
// Assumes APB writes land at the access edge and one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "arbc_defs.vh"

module arbc_monitor (
  input wire       ref_clk,
  input wire       arst_n,
  input wire       psel,
  input wire       penable,
  input wire       pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [1:0] recordHighpassSelect,
  input wire       hpfEnable,
  input wire [1:0] hpfCutoff,
  input wire [7:0] decimRatio,
  input wire [12:0] latencyTicks,
  input wire [1:0] micPreampGainSelect,
  input wire [1:0] micPreampGainDb6,
  input wire       monoSourceSelect,
  input wire       micBiasPowerDown,
  input wire       commonModeRefPowerDown,
  input wire [6:0] bypassLeftLevel,
  input wire [6:0] bypassRightLevel,
  input wire       bypassPowerDown
);
  logic [15:0] pwrSh_ff;
  logic        monoSh_ff;
  logic [7:0]  gap_ff;
  wire         wrEn = psel && penable && pwrite;

  // ==========
  // Shadow registers and step spacing
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrSh_ff <= `ARBC_RST_PWR;
      monoSh_ff <= 1'b0;
      gap_ff <= 8'h00;
    end else begin
      if (wrEn && paddr == `ARBC_OFS_PWR) pwrSh_ff <= pwdata[15:0];
      if (wrEn && paddr == `ARBC_OFS_MISC) monoSh_ff <= pwdata[`ARBC_MONO_SOURCE_SELECT_BIT];
      if ($changed(bypassLeftLevel)) gap_ff <= 8'h00;
      else if (gap_ff != 8'hff) gap_ff <= gap_ff + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ==========
  // Assertions
  hpf_on_a: assert property (hpfEnable == ($past(recordHighpassSelect) != 2'b00))
    else $error("hpfEnable wrong");
  hpf_code_a: assert property (hpfCutoff == $past(recordHighpassSelect))
    else $error("hpfCutoff wrong");
  osr_lat_a: assert property (decimRatio == 8'd128 && latencyTicks == 13'd3674)
    else $error("rate setup wrong");
  mic_preamp_gain_select_map_a: assert property (micPreampGainDb6 == {&micPreampGainSelect,
    micPreampGainSelect == 2'b10})
    else $error("preamp gain wrong");
  mono_sel_a: assert property (monoSourceSelect == monoSh_ff)
    else $error("mono source wrong");
  micb_pd_a: assert property (micBiasPowerDown == (pwrSh_ff[6] || pwrSh_ff[15]))
    else $error("mic bias wrong");
  vcm_pd_a: assert property (commonModeRefPowerDown == (pwrSh_ff[15] && pwrSh_ff[14]))
    else $error("reference power wrong");
  byp_step_a: assert property ($changed(bypassLeftLevel) |-> gap_ff >= 8'd199 &&
    (bypassLeftLevel == $past(bypassLeftLevel) + 7'd1 ||
     bypassLeftLevel + 7'd1 == $past(bypassLeftLevel)))
    else $error("bypass step wrong");
  byp_pdown_a: assert property ($rose(bypassPowerDown) |-> $past(bypassLeftLevel) == 7'd0
    && $past(bypassRightLevel) == 7'd0)
    else $error("bypass off before mute");
  byp_pup_a: assert property ($fell(bypassPowerDown) |-> bypassLeftLevel == 7'd0
    && bypassRightLevel == 7'd0)
    else $error("bypass on not muted");

  cover property ($changed(bypassLeftLevel));
  cover property ($rose(bypassPowerDown));
  cover property ($fell(bypassPowerDown));
endmodule

bind arbc_top arbc_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .recordHighpassSelect(recordHighpassSelect), .hpfEnable(hpfEnable),
  .hpfCutoff(hpfCutoff), .decimRatio(decimRatio), .latencyTicks(latencyTicks),
  .micPreampGainSelect(micPreampGainSelect), .micPreampGainDb6(micPreampGainDb6),
  .monoSourceSelect(monoSourceSelect), .micBiasPowerDown(micBiasPowerDown),
  .commonModeRefPowerDown(commonModeRefPowerDown), .bypassLeftLevel(bypassLeftLevel),
  .bypassRightLevel(bypassRightLevel), .bypassPowerDown(bypassPowerDown));
`default_nettype wire

// file: sim/arbc_apb_host.sv
// APB host model issuing register transfers for the bench.
// Assumes the slave answers with pready sampled on a rising edge.
`timescale 1ns/100ps
`default_nettype none

module arbc_apb_host (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: sim/audio_record_bypass_control_bench.sv
// Self-checking bench of the record and bypass control block.
// Assumes a 10 MHz clock and the APB host model on the register port.
`timescale 1ns/100ps
`default_nettype none
`include "arbc_defs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", n, e, a); end end

module audio_record_bypass_control_bench;
  logic        ref_clk;
  logic        arst_n;
  wire         psel, penable, pwrite, pready, hpfEnable, monoSourceSelect, bypassPowerDown;
  wire  [7:0]  paddr, decimRatio;
  wire  [31:0] pwdata, prdata;
  wire  [1:0]  hpfCutoff, leftRecordSourceSelect, micPreampGainDb6;
  wire  [12:0] latencyTicks;
  wire  [6:0]  bypassLeftLevel, bypassRightLevel;
  wire  [8:0]  pdv;
  wire         pslverr, adcLeftMute, adcRightMute;
  wire  [2:0]  modClkDiv;
  wire  [1:0]  rightRecordSourceSelect;
  wire  [6:0]  adcLeftGain, adcRightGain;
  logic [31:0] expQ[$];
  logic [31:0] v, e0;
  logic [15:0] pw[4] = '{16'h0040, 16'hc000, 16'h8000, 16'h1f30};
  int          err_total, compares, i;
  int          seed = 32'hcc44;

  arbc_apb_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  arbc_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .recordHighpassSelect(), .hpfEnable(hpfEnable),
    .hpfCutoff(hpfCutoff), .modClkDiv(modClkDiv), .decimRatio(decimRatio),
    .latencyTicks(latencyTicks), .leftRecordSourceSelect(leftRecordSourceSelect),
    .rightRecordSourceSelect(rightRecordSourceSelect), .micPreampGainSelect(),
    .micPreampGainDb6(micPreampGainDb6), .adcLeftGain(adcLeftGain),
    .adcLeftMute(adcLeftMute), .adcRightGain(adcRightGain),
    .adcRightMute(adcRightMute), .bypassLeftLevel(bypassLeftLevel),
    .bypassRightLevel(bypassRightLevel), .bypassPowerDown(bypassPowerDown),
    .monoSourceSelect(monoSourceSelect), .micBiasPowerDown(pdv[2]),
    .headphonePowerDown(pdv[7]), .monoPowerDown(pdv[6]), .dacPowerDown(pdv[5]),
    .adcLeftPowerDown(pdv[4]), .adcRightPowerDown(pdv[3]), .oscPowerDown(pdv[1]),
    .clkBufPowerDown(pdv[0]), .commonModeRefPowerDown(pdv[8]));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========
  // Read data scoreboard
  always @(posedge ref_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      e0 = expQ.pop_front();
      `CHK("prdata", e0, prdata)
      `CHK("pslverr", paddr > 8'h14 || paddr[1:0] != 2'h0, pslverr)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    expQ.push_back(e);
    host.xfer(1'b0, a, 32'h0, r);
  endtask

  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic waitLvl(input logic [6:0] l, input logic [6:0] r);
    int n;
    n = 0;
    while ({bypassLeftLevel, bypassRightLevel} !== {l, r} && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("levels", {l, r}, {bypassLeftLevel, bypassRightLevel})
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict;
  end

  // ==========
  // Test sequence
  initial begin
    arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    settle;
    `CHK("hpf", 3'b111, {hpfEnable, hpfCutoff})
    `CHK("ratio", 8'd128, decimRatio)
    `CHK("latency", 13'd3674, latencyTicks)
    rd(`ARBC_OFS_CTRL, 32'h0000c001);
    rd(`ARBC_OFS_BYPVOL, 32'h00004848);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      v[15:14] = i[1:0];
      v[13:12] = i[1:0];
      v[9:8] = i[1:0];
      v[7:6] = i[1:0];
      v[5] = 1'b0;
      wr(`ARBC_OFS_CTRL, v);
      rd(`ARBC_OFS_CTRL, {16'h0000, v[15:0]});
      settle;
      `CHK("hpf", {i != 0, i[1:0]}, {hpfEnable, hpfCutoff})
      `CHK("source", i[1:0], leftRecordSourceSelect)
      `CHK("rsource", v[11:10], rightRecordSourceSelect)
      `CHK("modclk", (i == 1) ? 3'h3 : (i == 2) ? 3'h4 : 3'h2, modClkDiv)
      `CHK("micgain", {i[1] & i[0], i[1] & ~i[0]}, micPreampGainDb6)
    end
    $display("test control done");
    wr(`ARBC_OFS_MISC, 32'h4);
    settle;
    `CHK("mono", 1'b1, monoSourceSelect)
    wr(`ARBC_OFS_MISC, 32'h0);
    settle;
    `CHK("mono", 1'b0, monoSourceSelect)
    rd(8'h18, 32'h0);
    wr(`ARBC_OFS_PWR, 32'h0);
    wr(`ARBC_OFS_ADCVOL, 32'h0a7f);
    settle;
    `CHK("adcvol", {7'h0a, 1'b0, 7'h7f, 1'b1}, {adcLeftGain, adcLeftMute, adcRightGain, adcRightMute})
    for (i = 0; i < 4; i++) begin
      wr(`ARBC_OFS_PWR, {16'h0000, pw[i]});
      settle;
      `CHK("powerdown", {pw[i][15] & pw[i][14], pw[i][12:8] | {5{pw[i][15]}}, pw[i][6:4] | {3{pw[i][15]}}}, pdv)
      rd(`ARBC_OFS_PWR, {16'h0000, pw[i]});
    end
    $display("test power done");
    wr(`ARBC_OFS_BYPVOL, 32'h0302);
    wr(`ARBC_OFS_PWR, 32'h0770);
    settle;
    `CHK("bypass off", 1'b0, bypassPowerDown)
    `CHK("start level", 14'h0, {bypassLeftLevel, bypassRightLevel})
    waitLvl(7'd1, 7'd1);
    wr(`ARBC_OFS_BYPVOL, 32'h0105);
    waitLvl(7'd1, 7'd5);
    wr(`ARBC_OFS_PWR, 32'h2770);
    settle;
    `CHK("bypass off", 1'b0, bypassPowerDown)
    waitLvl(7'd0, 7'd0);
    settle;
    `CHK("bypass off", 1'b1, bypassPowerDown)
    rd(`ARBC_OFS_STAT, 32'h0);
    $display("test bypass done");
    print_verdict;
  end
endmodule
`default_nettype wire
